// File: dic_ahb_slave.sv
// ahb-lite slave front end, zero wait states, always okay
// assumes hsel already decodes the block's region; word accesses only
`default_nettype none
module dic_ahb_slave
  import dic_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // ahb-lite slave port
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // register file side
  dic_reg_if.bus rb
);
  logic sel_w;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;

  // non-word sizes are dropped rather than half-written
  assign sel_w = hsel_in && hready_in && htrans_in[1] &&
                 (hsize_in == 3'h2);

  // write data arrives one cycle after its address phase
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= sel_w && hwrite_in;
      wr_addr_q <= haddr_in[7:0];
    end
  end

  // read data is fetched at the address phase so no wait is needed
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_q <= 32'h0000_0000;
    end else if (sel_w && !hwrite_in) begin
      hrdata_q <= rb.rd_data;
    end
  end

  assign rb.wr_en = wr_pend_q;
  assign rb.wr_addr = wr_addr_q;
  assign rb.wr_data = hwdata_in;
  assign rb.rd_addr = haddr_in[7:0];
  assign hrdata_out = hrdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
endmodule
`default_nettype wire

// File: dic_chk.sv
// port-level assertions for the dac i2c control block
// assumes binding to dic_top; every check runs on the system clock
`default_nettype none
module dic_chk
  import dic_pkg::*;
#(
  parameter int EXIT_NS = PD_EXIT_NS
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // watched outputs
  input wire logic sda_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [15:0] dac_code_out,
  input wire logic [1:0] power_down_state_out,
  input wire logic fast_settle_out,
  input wire logic out_valid_out
);
  localparam int EXIT_CYC = (EXIT_NS * CLK_MHZ + 999) / 1000;
  logic [15:0] low_q;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // counts active cycles with the output not yet valid after an exit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_q <= '0;
    end else if (out_valid_out || power_down_state_out != PD_NONE) begin
      low_q <= '0;
    end else begin
      low_q <= low_q + 16'h0001;
    end
  end
  chk_bus_okay: assert property (hresp_out == 1'b0 && hreadyout_out)
    else $error("bus answer not okay or not ready");
  chk_sda_low: assert property (sda_out == 1'b0)
    else $error("sda data value is not low");
  chk_reset_clear: assert property ($fell(rst_in) |->
    dac_code_out == DAC_RST && power_down_state_out == PD_NONE)
    else $error("code or power state not cleared by reset");
  chk_pd_invalid: assert property (
    (power_down_state_out != PD_NONE) [*2] |-> !out_valid_out)
    else $error("output valid while powered down");
  chk_exit_count: assert property ($rose(out_valid_out) |->
    low_q >= EXIT_CYC - 1 && low_q <= EXIT_CYC + 1)
    else $error("exit delay length wrong");
  chk_exit_bound: assert property (low_q <= EXIT_CYC + 1)
    else $error("exit delay overran");
  chk_pd_hold: assert property (
    (power_down_state_out != PD_NONE) [*2] |-> $stable(dac_code_out))
    else $error("code changed during power-down");
  chk_fast_keep: assert property (
    $changed(dac_code_out) |-> $stable(fast_settle_out))
    else $error("data update changed settling choice");
  chk_update_wakes: assert property ($changed(dac_code_out) |->
    ##[0:2] power_down_state_out == PD_NONE)
    else $error("data update left device powered down");
  chk_active_valid: assert property (
    power_down_state_out == PD_NONE && $past(out_valid_out) &&
    $past(power_down_state_out) == PD_NONE |-> out_valid_out)
    else $error("valid dropped while active");
endmodule
`default_nettype wire

// File: dic_i2c_master.sv
// behavioural i2c bus master: drives scl, pulls sda low when asked
// assumes the bench resolves sda with a pull-up; scl rests high
`default_nettype none
module dic_i2c_master (
  // link wires
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 10ps;
  realtime q = 3.75; // quarter of the 15 ns link period
  realtime stall = 0.0; // extra low time models a slow master
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // two idle pulses so the slave's enable synchroniser fills
  task automatic warm();
    repeat (2) begin
      scl_out = 1'b0;
      #(2 * q);
      scl_out = 1'b1;
      #(2 * q);
    end
  endtask
  // start, also used as repeated start
  task automatic start();
    sda_low_out = 1'b0;
    #q;
    scl_out = 1'b1;
    #q;
    sda_low_out = 1'b1;
    #q;
    scl_out = 1'b0;
    #q;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #q;
    scl_out = 1'b1;
    #q;
    sda_low_out = 1'b0;
    #q;
  endtask
  // data changes only while scl is low, sampled mid high phase
  task automatic bit_x(input logic v, output logic b);
    sda_low_out = !v;
    #(q + stall);
    scl_out = 1'b1;
    #q;
    b = sda_in;
    #q;
    scl_out = 1'b0;
    #q;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], b);
    end
    bit_x(1'b1, b);
    ack = !b;
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(!ack, b);
  endtask
endmodule
`default_nettype wire

// File: dic_pkg.sv
// constants shared by the dac i2c control block
// assumes a 25 MHz system clock and a 7-bit slave address scheme
`default_nettype none
package dic_pkg;
  // system clock and power-down exit timing
  localparam int CLK_MHZ = 25;
  localparam int PD_EXIT_NS = 2500;
  localparam int PD_EXIT_CYC = (PD_EXIT_NS * CLK_MHZ + 999) / 1000;
  // link addresses: own 7-bit address and the shared broadcast byte
  localparam logic [6:0] SLV_ADDR = 7'h4C;
  localparam logic [7:0] BCAST_ADDR = 8'h90;
  // control byte fields
  localparam int CTRL_PWR_BIT = 0;
  localparam int LD_MODE_HI = 5;
  localparam int LD_MODE_LO = 4;
  localparam logic [1:0] LD_TEMP = 2'h0;
  localparam logic [1:0] LD_DIRECT = 2'h1;
  // power setting field in the data high byte
  localparam int M_PWR_HI = 7;
  localparam int M_PWR_LO = 5;
  localparam logic [1:0] PD_NONE = 2'h0;
  // reset values
  localparam logic [15:0] DAC_RST = 16'h0000;
  localparam logic [2:0] PWR_RST = 3'h0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CODE = 8'h00;
  localparam logic [7:0] REG_POWER = 8'h04;
  localparam logic [7:0] REG_LAST = 8'h08;
  localparam logic [7:0] REG_CTRL = 8'h0C;
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int PWR_FAST_BIT = 2;
  localparam int PWR_VALID_BIT = 3;
  localparam int PWR_PEND_BIT = 4;
  // link byte framing
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] RB_LAST = 2'h2;
endpackage
`default_nettype wire

// File: dic_reg_if.sv
// register access carrier between the bus slave and the register file
// assumes both ends run on the system clock
`default_nettype none
interface dic_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  // bus side drives requests, register side answers reads
  modport bus (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport regs (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// File: dic_top.sv
// digital control of a 16-bit voltage dac reached as an i2c slave
// assumes scl_clk_in is the bus clock (may stop between frames) and the
// open-drain sda wire is resolved outside from sda_oe_out
`default_nettype none
module dic_top
  import dic_pkg::*;
#(
  parameter int EXIT_NS = PD_EXIT_NS
) (
  // system clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // i2c link, sda split into input, output and enable
  input wire logic scl_clk_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // ahb-lite register port
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  // converter state
  output logic [15:0] dac_code_out,
  output logic [1:0] power_down_state_out,
  output logic fast_settle_out,
  output logic out_valid_out
);
  localparam int EXIT_CYC = (EXIT_NS * CLK_MHZ + 999) / 1000;

  // the exit counter is 12 bits wide
  if (EXIT_CYC < 1 || EXIT_CYC > 4095) begin : g_exit_chk
    $error("exit delay does not fit the counter");
  end

  typedef enum logic [1:0] {LS_IDLE, LS_ADDR, LS_WR, LS_RD} dic_link_t;

  dic_reg_if rif ();

  // ---------------- link domain (scl) ----------------
  dic_link_t st_q;
  logic start_tgl_q;
  logic start_seen_q;
  logic [3:0] cnt_q;
  logic [6:0] sh_q;
  logic ack_q;
  logic [1:0] idx_q;
  logic [7:0] ctrl_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic req_tgl_q;
  logic upd_tgl_q;
  logic oe_q;
  logic en_s1_q;
  logic en_s2_q;
  logic new_start_w;
  logic [7:0] byte_w;
  logic own_w;
  logic bc_w;
  logic [7:0] tx_w;
  logic tx_bit_w;
  logic link_en_q;

  // start seen as sda falling while scl is high; flips a toggle that
  // the scl domain compares on its next rising edge
  always_ff @(negedge sda_in or posedge rst_in) begin
    if (rst_in) begin
      start_tgl_q <= 1'b0;
    end else if (scl_clk_in) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  // enable level from the register file, two flops on the link clock
  always_ff @(posedge scl_clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end else begin
      en_s1_q <= link_en_q;
      en_s2_q <= en_s1_q;
    end
  end

  assign new_start_w = start_tgl_q != start_seen_q;
  assign byte_w = {sh_q, sda_in};
  assign own_w = en_s2_q && (byte_w[7:1] == SLV_ADDR);
  assign bc_w = en_s2_q && (byte_w == BCAST_ADDR);

  // readback order high, low, control
  always_comb begin
    case (idx_q)
      2'h0: tx_w = hi_q;
      2'h1: tx_w = lo_q;
      default: tx_w = ctrl_q;
    endcase
  end
  assign tx_bit_w = tx_w[3'h7 - cnt_q[2:0]];

  // bit counting, address match and byte capture on scl rising edges
  always_ff @(posedge scl_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= LS_IDLE;
      start_seen_q <= 1'b0;
      cnt_q <= 4'h0;
      sh_q <= 7'h00;
      ack_q <= 1'b0;
      idx_q <= 2'h0;
      ctrl_q <= 8'h00;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      req_tgl_q <= 1'b0;
    end else begin
      start_seen_q <= start_tgl_q;
      if (new_start_w) begin
        // this edge already carries the first address bit
        st_q <= LS_ADDR;
        cnt_q <= 4'h1;
        sh_q <= {6'h00, sda_in};
        ack_q <= 1'b0;
      end else begin
        case (st_q)
          LS_IDLE: begin
            cnt_q <= 4'h0;
          end
          LS_ADDR, LS_WR: begin
            if (cnt_q == ACK_SLOT) begin
              cnt_q <= 4'h0;
              ack_q <= 1'b0;
            end else begin
              sh_q <= byte_w[6:0];
              cnt_q <= cnt_q + 4'h1;
              if (cnt_q == 4'h7 && st_q == LS_ADDR) begin
                // foreign addresses and the speed code fall out here
                if (own_w || bc_w) begin
                  ack_q <= 1'b1;
                  idx_q <= 2'h0;
                  st_q <= (own_w && byte_w[0]) ? LS_RD : LS_WR;
                end else begin
                  st_q <= LS_IDLE;
                end
              end else if (cnt_q == 4'h7) begin
                ack_q <= 1'b1;
                case (idx_q)
                  2'h0: begin
                    ctrl_q <= byte_w;
                    idx_q <= 2'h1;
                  end
                  2'h1: begin
                    hi_q <= byte_w;
                    idx_q <= 2'h2;
                  end
                  default: begin
                    // next pair streams without a new address
                    lo_q <= byte_w;
                    idx_q <= 2'h1;
                    req_tgl_q <= ~req_tgl_q;
                  end
                endcase
              end
            end
          end
          LS_RD: begin
            if (cnt_q == ACK_SLOT) begin
              cnt_q <= 4'h0;
              ack_q <= 1'b0;
              if (!ack_q) begin
                // master's answer: nack ends the read
                if (sda_in) begin
                  st_q <= LS_IDLE;
                end else begin
                  idx_q <= (idx_q == RB_LAST) ? 2'h0 : idx_q + 2'h1;
                end
              end
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
          default: st_q <= LS_IDLE;
        endcase
      end
    end
  end

  // sda is driven and updates are released on scl falling edges
  always_ff @(negedge scl_clk_in or posedge rst_in) begin
    if (rst_in) begin
      oe_q <= 1'b0;
      upd_tgl_q <= 1'b0;
    end else begin
      oe_q <= (cnt_q == ACK_SLOT && ack_q) ||
              (st_q == LS_RD && cnt_q != ACK_SLOT && !tx_bit_w);
      // count back at zero means this is the end of the ack bit
      if (cnt_q == 4'h0) begin
        upd_tgl_q <= req_tgl_q;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = oe_q;

  // ---------------- system domain ----------------
  logic upd_s1_q;
  logic upd_s2_q;
  logic upd_s3_q;
  logic evt_w;
  logic [1:0] ld_w;
  logic c0_w;
  logic pw_direct_w;
  logic pw_temp_w;
  logic data_upd_w;
  logic [2:0] pw_val_w;
  logic pd_leave_w;
  logic [15:0] dac_q;
  logic [15:0] temp_q;
  logic [2:0] tpw_q;
  logic tpw_pend_q;
  logic [1:0] pd_q;
  logic fast_q;
  logic [11:0] exit_cnt_q;
  logic valid_q;
  logic [23:0] last_q;

  // update toggle crosses with two flops, third flop finds the edge;
  // link bytes stay still for a whole byte after it, so reading
  // them on the event is safe at any sane scl to clk ratio
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      upd_s1_q <= 1'b0;
      upd_s2_q <= 1'b0;
      upd_s3_q <= 1'b0;
    end else begin
      upd_s1_q <= upd_tgl_q;
      upd_s2_q <= upd_s1_q;
      upd_s3_q <= upd_s2_q;
    end
  end

  assign evt_w = upd_s2_q ^ upd_s3_q;
  assign ld_w = ctrl_q[LD_MODE_HI:LD_MODE_LO];
  assign c0_w = ctrl_q[CTRL_PWR_BIT];
  // direct or broadcast power write
  assign pw_direct_w = evt_w && c0_w && (ld_w != LD_TEMP);
  // update from a staged power setting
  assign pw_temp_w = evt_w && !c0_w && ld_w[1] && tpw_pend_q;
  assign data_upd_w = evt_w && !c0_w &&
                      (ld_w == LD_DIRECT || (ld_w[1] && !tpw_pend_q));
  assign pw_val_w = pw_direct_w ? hi_q[M_PWR_HI:M_PWR_LO] : tpw_q;
  assign pd_leave_w = (pd_q != PD_NONE) && (data_upd_w ||
                      ((pw_direct_w || pw_temp_w) && pw_val_w[2:1] == 2'h0));

  // dac and temporary data registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dac_q <= DAC_RST;
      temp_q <= DAC_RST;
    end else if (evt_w && !c0_w) begin
      if (ld_w == LD_TEMP) begin
        temp_q <= {hi_q, lo_q};
      end else if (ld_w == LD_DIRECT) begin
        temp_q <= {hi_q, lo_q};
        dac_q <= {hi_q, lo_q};
      end else if (!tpw_pend_q) begin
        dac_q <= temp_q;
      end
    end
  end

  // staged power setting waits for a later update
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tpw_q <= PWR_RST;
      tpw_pend_q <= 1'b0;
    end else if (evt_w && c0_w && ld_w == LD_TEMP) begin
      tpw_q <= hi_q[M_PWR_HI:M_PWR_LO];
      tpw_pend_q <= 1'b1;
    end else if (pw_temp_w) begin
      tpw_pend_q <= 1'b0;
    end
  end

  // power state; dac register is left alone throughout power-down
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pd_q <= PD_NONE;
      fast_q <= PWR_RST[0];
    end else if (pw_direct_w || pw_temp_w) begin
      if (pw_val_w[2:1] == 2'h0) begin
        fast_q <= pw_val_w[0];
        pd_q <= PD_NONE;
      end else begin
        pd_q <= pw_val_w[2:1];
      end
    end else if (data_upd_w) begin
      pd_q <= PD_NONE;
    end
  end

  // fast_q only moves on a power write, never on data updates

  // output waits out the amplifier restart after leaving power-down
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      exit_cnt_q <= 12'h000;
      valid_q <= 1'b1;
    end else begin
      if (pd_leave_w) begin
        exit_cnt_q <= 12'(EXIT_CYC);
      end else if (exit_cnt_q != 12'h000) begin
        exit_cnt_q <= exit_cnt_q - 12'h001;
      end
      valid_q <= !pd_leave_w && pd_q == PD_NONE &&
                 exit_cnt_q <= 12'h001;
    end
  end

  // last written bytes, kept for software
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_q <= 24'h000000;
    end else if (evt_w) begin
      last_q <= {ctrl_q, hi_q, lo_q};
    end
  end

  // control register: bit 0 lets the link answer at all
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      link_en_q <= CTRL_RST[CTRL_EN_BIT];
    end else if (rif.wr_en && rif.wr_addr == REG_CTRL) begin
      link_en_q <= rif.wr_data[CTRL_EN_BIT];
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rif.rd_data = 32'h0000_0000;
    case (rif.rd_addr)
      REG_CODE: rif.rd_data[15:0] = dac_q;
      REG_POWER: begin
        rif.rd_data[1:0] = pd_q;
        rif.rd_data[PWR_FAST_BIT] = fast_q;
        rif.rd_data[PWR_VALID_BIT] = valid_q;
        rif.rd_data[PWR_PEND_BIT] = tpw_pend_q;
      end
      REG_LAST: rif.rd_data[23:0] = last_q;
      REG_CTRL: rif.rd_data[CTRL_EN_BIT] = link_en_q;
      default: rif.rd_data = 32'h0000_0000;
    endcase
  end

  dic_ahb_slave u_ahb (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(hsize_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .hrdata_out(hrdata_out),
    .rb(rif.bus)
  );

  assign dac_code_out = dac_q;
  assign power_down_state_out = pd_q;
  assign fast_settle_out = fast_q;
  assign out_valid_out = valid_q;
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench: ahb register master plus i2c master model
// assumes dic_top, its package and the checker are compiled first
`default_nettype none
module tb_top
  import dic_pkg::*;
;
  timeunit 1ns;
  timeprecision 10ps;
  localparam int EXIT = 200; // shortens the exit delay to five cycles
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire logic hready, hresp, sda_o, sda_oe, scl, m_low, fast, valid;
  wire logic [31:0] hrdata;
  wire logic [15:0] code;
  wire logic [1:0] pd;
  // open drain wire with pull-up
  wire logic sda = (sda_oe ? sda_o : 1'b1) && !m_low;
  int n_mismatch = 0;
  int comparisons = 0;
  always #20 clk_in = !clk_in;
  dic_top #(.EXIT_NS(EXIT)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .scl_clk_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
    .hresp_out(hresp), .hrdata_out(hrdata), .dac_code_out(code),
    .power_down_state_out(pd), .fast_settle_out(fast),
    .out_valid_out(valid));
  dic_i2c_master m (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));
  task automatic check(input string what, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one single word transfer; read data taken at the data phase edge
  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_in);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic send(input logic [7:0] b, input logic e);
    logic a;
    m.wr_byte(b, a);
    check("ack", {31'h0, a}, {31'h0, e});
  endtask
  task automatic frame(input logic [7:0] a, c, h, l);
    m.start();
    send(a, 1'b1);
    send(c, 1'b1);
    send(h, 1'b1);
    send(l, 1'b1);
    m.stop();
    repeat (8) @(posedge clk_in);
  endtask
  task automatic chk_pwr(input logic [1:0] p, input logic f);
    check("power", {30'h0, pd}, {30'h0, p});
    check("fast", {31'h0, fast}, {31'h0, f});
  endtask
  task automatic t_regs();
    logic [31:0] r;
    check("code", {16'h0, code}, {16'h0, DAC_RST});
    chk_pwr(PD_NONE, 1'b0);
    ahb(1'b0, REG_POWER, 32'h0, r);
    check("power reg", r, 32'h0000_0001 << PWR_VALID_BIT);
    ahb(1'b1, REG_CODE, 32'h0000_BEEF, r);
    ahb(1'b0, REG_CODE, 32'h0, r);
    check("code reg", r, 32'h0);
    ahb(1'b0, 8'h10, 32'h0, r);
    check("unmapped", r, 32'h0);
    ahb(1'b0, REG_CTRL, 32'h0, r);
    check("ctrl reg", r, CTRL_RST);
    ahb(1'b1, REG_CTRL, 32'h0, r);
    m.start();
    send(8'h98, 1'b0);
    m.stop();
    ahb(1'b1, REG_CTRL, 32'h1, r);
    $display("t_regs done");
  endtask
  task automatic t_direct();
    logic [31:0] r;
    logic [7:0] d;
    frame(8'h98, 8'h10, 8'h12, 8'h34);
    check("code", {16'h0, code}, 32'h0000_1234);
    ahb(1'b0, REG_LAST, 32'h0, r);
    check("last", r, 32'h0010_1234);
    m.start();
    send(8'h99, 1'b1);
    m.rd_byte(1'b1, d);
    check("rb high", {24'h0, d}, 32'h12);
    m.rd_byte(1'b1, d);
    check("rb low", {24'h0, d}, 32'h34);
    m.rd_byte(1'b0, d);
    check("rb ctrl", {24'h0, d}, 32'h10);
    m.stop();
    $display("t_direct done");
  endtask
  task automatic t_stream();
    m.start();
    send(8'h08, 1'b0);
    m.start();
    send(8'h98, 1'b1);
    send(8'h10, 1'b1);
    m.stall = 20.0;
    for (int i = 1; i < 4; i++) begin
      send(8'h00, 1'b1);
      send(i[7:0], 1'b1);
      repeat (8) @(posedge clk_in);
      check("stream", {16'h0, code}, i);
    end
    m.stall = 0.0;
    m.stop();
    $display("t_stream done");
  endtask
  task automatic t_temp();
    frame(8'h98, 8'h00, 8'hAB, 8'hCD);
    check("temp", {16'h0, code}, 32'h3);
    frame(8'h90, 8'h30, 8'h00, 8'h00);
    check("bcast", {16'h0, code}, 32'hABCD);
    m.start();
    send(8'h9A, 1'b0);
    m.start();
    send(8'h91, 1'b0);
    m.stop();
    $display("t_temp done");
  endtask
  task automatic t_power();
    logic [1:0] p;
    logic f;
    p = 2'h0;
    f = 1'b0;
    for (int v = 0; v < 8; v++) begin
      m.start();
      send(8'h98, 1'b1);
      send(8'h11, 1'b1);
      send({v[2:0], 5'h00}, 1'b1);
      repeat (8) @(posedge clk_in);
      chk_pwr(p, f);
      send(8'h00, 1'b1);
      m.stop();
      repeat (8) @(posedge clk_in);
      p = v[2:1];
      f = (v < 2) ? v[0] : f;
      chk_pwr(p, f);
    end
    frame(8'h98, 8'h10, 8'h56, 8'h78);
    repeat (10) @(posedge clk_in);
    chk_pwr(PD_NONE, 1'b1);
    check("valid", {31'h0, valid}, 32'h1);
    frame(8'h98, 8'h11, 8'h00, 8'h00);
    chk_pwr(PD_NONE, 1'b0);
    $display("t_power done");
  endtask
  task automatic t_stage();
    logic [31:0] r;
    frame(8'h98, 8'h01, 8'hC0, 8'h00);
    chk_pwr(PD_NONE, 1'b0);
    ahb(1'b0, REG_POWER, 32'h0, r);
    check("pending", {31'h0, r[PWR_PEND_BIT]}, 32'h1);
    frame(8'h90, 8'h30, 8'h00, 8'h00);
    chk_pwr(2'h3, 1'b0);
    frame(8'h98, 8'h10, 8'h00, 8'h01);
    chk_pwr(PD_NONE, 1'b0);
    $display("t_stage done");
  endtask
  // watchdog: the whole sequence needs well under 100 us
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    m.warm();
    t_regs();
    t_direct();
    t_stream();
    t_temp();
    t_power();
    t_stage();
    tally_and_finish();
  end
endmodule
bind dic_top dic_chk #(.EXIT_NS(EXIT_NS)) u_chk (.clk_in(clk_in),
  .rst_in(rst_in), .sda_out(sda_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .dac_code_out(dac_code_out),
  .power_down_state_out(power_down_state_out),
  .fast_settle_out(fast_settle_out), .out_valid_out(out_valid_out));
`default_nettype wire
